// >>> src/pin_function_select.sv
// Notes on behaviour
// - Each pad has a 4-bit selector field.
// - Selector steers only output data and enable.
// - Pad input always reaches all sharing peripherals.
// - No checking of selector against peripherals.
// - Value zero leaves ordinary pads undriven.
// - Single memory pads: 1h selects memory signal.
// - Dual pads: 1h memory, 8h general IO.
// - Clock pad: 1h gated, 2h divided clock.
// - Debug pad: 0/8h debug clock, 1h IO.
// - Fields without a pad only tri-state.
// - Group 1 maps address, bank to bank7.
// - Group 2 maps address 12..6 with IO.
// - All fields read/write, reset to zero.
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`default_nettype none

module pin_function_select #(
    // Width of the Wishbone byte address.
    parameter int ADR_WIDTH = pin_function_select_pkg::MIN_ADR_WIDTH
) (
    // Register clock, 20 MHz.
    input wire logic ref_clk,
    // Synchronous reset, active high.
    input wire logic rst,
    // Wishbone slave port.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [pin_function_select_pkg::NUM_LANES-1:0] wb_sel_i,
    input wire logic [pin_function_select_pkg::REG_WIDTH-1:0] wb_dat_i,
    output logic [pin_function_select_pkg::REG_WIDTH-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Memory controller strobes and their enables.
    input wire logic mem_write_strobe_out,
    input wire logic mem_write_strobe_oe,
    input wire logic mem_row_strobe_out,
    input wire logic mem_row_strobe_oe,
    input wire logic mem_column_strobe_out,
    input wire logic mem_column_strobe_oe,
    input wire logic mem_chip_select_out,
    input wire logic mem_chip_select_oe,
    input wire logic mem_clock_enable_out,
    input wire logic mem_clock_enable_oe,
    // Memory clock gated by the power/sleep controller.
    input wire logic mem_clock_out_gated,
    // Memory clock from the divide-by-4.5 or system clock 5 source.
    input wire logic mem_clock_out_alt,
    // Memory address lines and bank address.
    input wire logic [12:0] mem_address_line_out,
    input wire logic [12:0] mem_address_line_oe,
    input wire logic [1:0] mem_bank_address_out,
    input wire logic [1:0] mem_bank_address_oe,
    // General-purpose IO banks 7 and 3.
    input wire logic [14:0] gpio_bank7_out,
    input wire logic [14:0] gpio_bank7_oe,
    input wire logic gpio_bank3_bit13_out,
    input wire logic gpio_bank3_bit13_oe,
    // Debug return clock.
    input wire logic debug_return_clock_out,
    input wire logic debug_return_clock_oe,
    // Pad buffers: level seen on each pad, data and enable driven to it.
    input wire logic [pin_function_select_pkg::NUM_PADS-1:0] pad_in,
    output logic [pin_function_select_pkg::NUM_PADS-1:0] pad_out,
    output logic [pin_function_select_pkg::NUM_PADS-1:0] pad_oe,
    // Pad levels fanned out to every peripheral that shares each pad.
    output logic [pin_function_select_pkg::NUM_PADS-1:0] pad_in_shared
);
    import pin_function_select_pkg::*;

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------

    // The decoder needs every register offset to fit the address.
    generate
        if (ADR_WIDTH < MIN_ADR_WIDTH) begin : g_bad_adr
            $error("ADR_WIDTH too small for the selector registers");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------

    // Selector registers, one word per group.
    logic [REG_WIDTH-1:0] group_q [NUM_GROUPS];
    // Bus request seen this cycle.
    logic bus_req;
    // Decoded register index and a hit flag.
    logic [2:0] reg_idx;
    logic reg_hit;
    // Per-pad source a and source b data and enables.
    logic [NUM_PADS-1:0] src_a_data;
    logic [NUM_PADS-1:0] src_a_oe;
    logic [NUM_PADS-1:0] src_b_data;
    logic [NUM_PADS-1:0] src_b_oe;

    assign bus_req = wb_cyc_i && wb_stb_i;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // Map the byte address onto a register; anything else is unmapped.
    always_comb begin
        reg_hit = 1'b1;
        reg_idx = 3'h0;
        if ((wb_adr_i >> MIN_ADR_WIDTH) != '0) begin
            reg_hit = 1'b0;
        end else if (wb_adr_i[4:0] == OFS_GROUP0) begin
            reg_idx = 3'h0;
        end else if (wb_adr_i[4:0] == OFS_GROUP1) begin
            reg_idx = 3'h1;
        end else if (wb_adr_i[4:0] == OFS_GROUP2) begin
            reg_idx = 3'h2;
        end else if (wb_adr_i[4:0] == OFS_GROUP3) begin
            reg_idx = 3'h3;
        end else if (wb_adr_i[4:0] == OFS_GROUP4) begin
            reg_idx = 3'h4;
        end else begin
            reg_hit = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone handshake
    // ----------------------------------------------------------------

    // Acknowledge one cycle after the request, and drop it the cycle after.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
        end
    end

    // Read data is captured with the acknowledge; unmapped reads return zero.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (bus_req && !wb_ack_o && reg_hit) begin
            wb_dat_o <= group_q[reg_idx];
        end else begin
            wb_dat_o <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Selector registers
    // ----------------------------------------------------------------

    // Writes land on the acknowledge edge, per byte lane; any value is stored
    // as is, since the block never checks a setting against its users.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                group_q[g] <= GROUP_RESET;
            end
        end else if (bus_req && wb_ack_o && wb_we_i && reg_hit) begin
            for (int b = 0; b < NUM_LANES; b++) begin
                if (wb_sel_i[b]) begin
                    group_q[reg_idx][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Source routing
    // ----------------------------------------------------------------

    // Source a of each pad, pad 21 in the top bit. Group 1 carries address
    // 5 down to 0 then bank bits 0 and 1; group 2 carries address 12 down to 6.
    always_comb begin
        src_a_data = {mem_address_line_out[6], mem_address_line_out[7],
                      mem_address_line_out[8], mem_address_line_out[9],
                      mem_address_line_out[10], mem_address_line_out[11],
                      mem_address_line_out[12],
                      mem_bank_address_out[1], mem_bank_address_out[0],
                      mem_address_line_out[0], mem_address_line_out[1],
                      mem_address_line_out[2], mem_address_line_out[3],
                      mem_address_line_out[4], mem_address_line_out[5],
                      debug_return_clock_out, mem_clock_enable_out,
                      mem_clock_out_gated, mem_chip_select_out,
                      mem_column_strobe_out, mem_row_strobe_out,
                      mem_write_strobe_out};
        src_a_oe = {mem_address_line_oe[6], mem_address_line_oe[7],
                    mem_address_line_oe[8], mem_address_line_oe[9],
                    mem_address_line_oe[10], mem_address_line_oe[11],
                    mem_address_line_oe[12],
                    mem_bank_address_oe[1], mem_bank_address_oe[0],
                    mem_address_line_oe[0], mem_address_line_oe[1],
                    mem_address_line_oe[2], mem_address_line_oe[3],
                    mem_address_line_oe[4], mem_address_line_oe[5],
                    debug_return_clock_oe, mem_clock_enable_oe,
                    1'b1, mem_chip_select_oe,
                    mem_column_strobe_oe, mem_row_strobe_oe,
                    mem_write_strobe_oe};
    end

    // Source b of each pad: IO bits on dual pads, the alternate memory clock,
    // and IO bank 7 bit 14 on the debug pad; single pads have none.
    always_comb begin
        src_b_data = {gpio_bank7_out[8], gpio_bank7_out[9], gpio_bank7_out[10],
                      gpio_bank7_out[11], gpio_bank7_out[12], gpio_bank7_out[13],
                      gpio_bank3_bit13_out,
                      gpio_bank7_out[0], gpio_bank7_out[1], gpio_bank7_out[2],
                      gpio_bank7_out[3], gpio_bank7_out[4], gpio_bank7_out[5],
                      gpio_bank7_out[6], gpio_bank7_out[7],
                      gpio_bank7_out[14], 1'b0, mem_clock_out_alt, 4'h0};
        src_b_oe = {gpio_bank7_oe[8], gpio_bank7_oe[9], gpio_bank7_oe[10],
                    gpio_bank7_oe[11], gpio_bank7_oe[12], gpio_bank7_oe[13],
                    gpio_bank3_bit13_oe,
                    gpio_bank7_oe[0], gpio_bank7_oe[1], gpio_bank7_oe[2],
                    gpio_bank7_oe[3], gpio_bank7_oe[4], gpio_bank7_oe[5],
                    gpio_bank7_oe[6], gpio_bank7_oe[7],
                    gpio_bank7_oe[14], 1'b0, 1'b1, 4'h0};
    end

    // ----------------------------------------------------------------
    // Pad multiplexers
    // ----------------------------------------------------------------

    // One mux per pad; groups 3 and 4 and the spare fields feed none, so
    // they can only ever leave nothing driven.
    generate
        for (genvar p = 0; p < NUM_PADS; p++) begin : g_pad
            pad_mux_cell #(
                .KIND(PAD_KIND[p])
            ) u_cell (
                .ref_clk(ref_clk),
                .rst(rst),
                .sel(group_q[PAD_GROUP[p]][PAD_FIELD[p]*SEL_WIDTH +: SEL_WIDTH]),
                .a_data(src_a_data[p]),
                .a_oe(src_a_oe[p]),
                .b_data(src_b_data[p]),
                .b_oe(src_b_oe[p]),
                .pad_out(pad_out[p]),
                .pad_oe(pad_oe[p])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Input fan-out
    // ----------------------------------------------------------------

    // Pad levels pass to every sharer whatever the selectors hold.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pad_in_shared <= '0;
        end else begin
            pad_in_shared <= pad_in;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    // Pads 0, 4, 6, 7, 14, 15 sit at group 0 f7, f3, f0; group 1 f7, f0; group 2 f6.
    property p_input_fanout;
        @(posedge ref_clk) disable iff (rst)
        !$rose(rst) |=> pad_in_shared == $past(pad_in);
    endproperty
    a_input_fanout: assert property (p_input_fanout)
        else $error("pad input not passed to sharers");

    property p_write_stored;
        @(posedge ref_clk) disable iff (rst)
        bus_req && wb_ack_o && wb_we_i && wb_sel_i == 4'hf && wb_adr_i == OFS_GROUP1
            |=> group_q[1] == $past(wb_dat_i);
    endproperty
    a_write_stored: assert property (p_write_stored)
        else $error("selector write not stored");

    property p_zero_tristate;
        @(posedge ref_clk) disable iff (rst)
        group_q[1][31:28] == SEL_TRISTATE |=> !pad_oe[7];
    endproperty
    a_zero_tristate: assert property (p_zero_tristate)
        else $error("zero selector left pad driven");

    property p_single_mem;
        @(posedge ref_clk) disable iff (rst)
        group_q[0][31:28] == SEL_MEMORY
            |=> pad_out[0] == $past(mem_write_strobe_out)
                && pad_oe[0] == $past(mem_write_strobe_oe);
    endproperty
    a_single_mem: assert property (p_single_mem)
        else $error("write strobe not routed");

    property p_reserved_off;
        @(posedge ref_clk) disable iff (rst)
        group_q[0][31:28] > SEL_MEMORY ##1 group_q[0][31:28] > SEL_MEMORY |-> !pad_oe[0];
    endproperty
    a_reserved_off: assert property (p_reserved_off)
        else $error("reserved selector drove pad");

    property p_dual_gpio;
        @(posedge ref_clk) disable iff (rst)
        group_q[1][31:28] == SEL_GPIO
            |=> pad_out[7] == $past(gpio_bank7_out[7]) && pad_oe[7] == $past(gpio_bank7_oe[7]);
    endproperty
    a_dual_gpio: assert property (p_dual_gpio)
        else $error("dual pad IO not routed");

    property p_bank_map;
        @(posedge ref_clk) disable iff (rst)
        group_q[1][3:0] == SEL_MEMORY |=> pad_out[14] == $past(mem_bank_address_out[1]);
    endproperty
    a_bank_map: assert property (p_bank_map)
        else $error("bank address 1 misrouted");

    property p_alt_clock;
        @(posedge ref_clk) disable iff (rst)
        group_q[0][15:12] == SEL_CLOCK_ALT
            |=> pad_out[4] == $past(mem_clock_out_alt) && pad_oe[4];
    endproperty
    a_alt_clock: assert property (p_alt_clock)
        else $error("alternate memory clock not routed");

    property p_debug_default;
        @(posedge ref_clk) disable iff (rst)
        group_q[0][3:0] == SEL_DEBUG_A || group_q[0][3:0] == SEL_DEBUG_B
            |=> pad_out[6] == $past(debug_return_clock_out);
    endproperty
    a_debug_default: assert property (p_debug_default)
        else $error("debug return clock not routed");

    property p_group2_gpio3;
        @(posedge ref_clk) disable iff (rst)
        group_q[2][27:24] == SEL_GPIO |=> pad_out[15] == $past(gpio_bank3_bit13_out);
    endproperty
    a_group2_gpio3: assert property (p_group2_gpio3)
        else $error("bank 3 bit 13 not routed");

    property p_ack_single;
        @(posedge ref_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single)
        else $error("acknowledge held too long");

endmodule // pin_function_select

`default_nettype wire

// >>> src/pin_function_select_pkg.sv
package pin_function_select_pkg;

    // ----------------------------------------------------------------
    // Register map and field layout
    // ----------------------------------------------------------------

    // Number of selector registers and width of each.
    localparam int NUM_GROUPS = 5;
    localparam int REG_WIDTH = 32;
    // Width of one selector field and the number of fields in a register.
    localparam int SEL_WIDTH = 4;
    localparam int FIELDS_PER_GROUP = 8;
    // Byte lanes of one register word.
    localparam int NUM_LANES = 4;
    // Smallest address width that reaches every selector register.
    localparam int MIN_ADR_WIDTH = 5;

    // Byte addresses of the selector registers.
    localparam logic [4:0] OFS_GROUP0 = 5'h00;
    localparam logic [4:0] OFS_GROUP1 = 5'h04;
    localparam logic [4:0] OFS_GROUP2 = 5'h08;
    localparam logic [4:0] OFS_GROUP3 = 5'h0c;
    localparam logic [4:0] OFS_GROUP4 = 5'h10;

    // Reset value of every selector register.
    localparam logic [31:0] GROUP_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Selector codes
    // ----------------------------------------------------------------

    // Value that leaves an ordinary pad undriven.
    localparam logic [3:0] SEL_TRISTATE = 4'h0;
    // Memory controller function on single and dual pads, gated clock on the clock pad.
    localparam logic [3:0] SEL_MEMORY = 4'h1;
    // Divided or system clock source on the memory clock pad.
    localparam logic [3:0] SEL_CLOCK_ALT = 4'h2;
    // General-purpose IO function on dual pads.
    localparam logic [3:0] SEL_GPIO = 4'h8;
    // Debug pad: both these values pick the debug return clock.
    localparam logic [3:0] SEL_DEBUG_A = 4'h0;
    localparam logic [3:0] SEL_DEBUG_B = 4'h8;
    // Debug pad: this value picks the general-purpose IO bit.
    localparam logic [3:0] SEL_DEBUG_GPIO = 4'h1;

    // ----------------------------------------------------------------
    // Pad classes and pad table
    // ----------------------------------------------------------------

    // Kind of pad, which fixes the codes its selector understands.
    localparam logic [1:0] KIND_SINGLE = 2'h0;
    localparam logic [1:0] KIND_DUAL = 2'h1;
    localparam logic [1:0] KIND_CLOCK = 2'h2;
    localparam logic [1:0] KIND_DEBUG = 2'h3;

    // Number of pads that have a selector field.
    localparam int NUM_PADS = 22;

    // Kind of each pad, pad 0 first.
    localparam logic [1:0] PAD_KIND [NUM_PADS] = '{
        KIND_SINGLE, KIND_SINGLE, KIND_SINGLE, KIND_SINGLE, KIND_CLOCK, KIND_SINGLE,
        KIND_DEBUG,
        KIND_DUAL, KIND_DUAL, KIND_DUAL, KIND_DUAL, KIND_DUAL, KIND_DUAL, KIND_DUAL,
        KIND_DUAL,
        KIND_DUAL, KIND_DUAL, KIND_DUAL, KIND_DUAL, KIND_DUAL, KIND_DUAL, KIND_DUAL};

    // Selector register that steers each pad.
    localparam int PAD_GROUP [NUM_PADS] = '{
        0, 0, 0, 0, 0, 0, 0,
        1, 1, 1, 1, 1, 1, 1, 1,
        2, 2, 2, 2, 2, 2, 2};

    // Field index (bits 4*n+3 down to 4*n) that steers each pad.
    localparam int PAD_FIELD [NUM_PADS] = '{
        7, 6, 5, 4, 3, 2, 0,
        7, 6, 5, 4, 3, 2, 1, 0,
        6, 5, 4, 3, 2, 1, 0};

endpackage

// >>> src/pad_mux_cell.sv
`timescale 1ns/10ps
`default_nettype none

// One pad's output mux: picks source a, source b or nothing from its selector.
module pad_mux_cell #(
    parameter logic [1:0] KIND = 2'h0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] sel,
    input wire logic a_data,
    input wire logic a_oe,
    input wire logic b_data,
    input wire logic b_oe,
    output logic pad_out,
    output logic pad_oe
);
    import pin_function_select_pkg::*;

    // ----------------------------------------------------------------
    // Code decode
    // ----------------------------------------------------------------

    // High when the selector names source a or source b.
    logic pick_a;
    logic pick_b;

    // Map the selector onto a source; every unlisted code picks neither.
    always_comb begin
        pick_a = 1'b0;
        pick_b = 1'b0;
        case (KIND)
            KIND_SINGLE: begin
                pick_a = (sel == SEL_MEMORY);
            end
            KIND_DUAL: begin
                pick_a = (sel == SEL_MEMORY);
                pick_b = (sel == SEL_GPIO);
            end
            KIND_CLOCK: begin
                pick_a = (sel == SEL_MEMORY);
                pick_b = (sel == SEL_CLOCK_ALT);
            end
            default: begin
                pick_a = (sel == SEL_DEBUG_A) || (sel == SEL_DEBUG_B);
                pick_b = (sel == SEL_DEBUG_GPIO);
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registered pad drive
    // ----------------------------------------------------------------

    // Only the chosen source reaches the buffer; reserved codes, and zero except on the debug pad, leave it undriven.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end else if (pick_a) begin
            pad_out <= a_data;
            pad_oe <= a_oe;
        end else if (pick_b) begin
            pad_out <= b_data;
            pad_oe <= b_oe;
        end else begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end
    end

endmodule // pad_mux_cell

`default_nettype wire

// >>> testbench/periph_pad_model.sv
`timescale 1ns/10ps
`default_nettype none
// Peripheral drivers and pad buffers: sources shift one place each cycle, and pad levels toggle where they mix with them.
module periph_pad_model (
    input wire logic ref_clk,
    input wire logic rst,
    output logic [75:0] src_q,
    output logic [21:0] lvl_q
);
    // Inverted feedback shift, so a stale or wrongly steered source shows at once.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_q <= 76'h0;
            lvl_q <= 22'h0;
        end else begin
            src_q <= {src_q[74:0], ~(src_q[75] ^ src_q[40])};
            lvl_q <= lvl_q ^ src_q[21:0] ^ 22'h2aaaaa;
        end
    end
endmodule // periph_pad_model
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pin_function_select_pkg::*;
    logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run_on, mon_on;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [31:0] shadow [5];
    logic [75:0] s;
    logic [21:0] pad_in, pad_out, pad_oe, pad_in_shared, exp_o, exp_e, in_q;
    logic [1:0] pe;
    int n_fail = 0, comparisons = 0, cycles = 0;
    pin_function_select uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mem_write_strobe_out(s[0]), .mem_write_strobe_oe(s[1]),
        .mem_row_strobe_out(s[2]), .mem_row_strobe_oe(s[3]),
        .mem_column_strobe_out(s[4]), .mem_column_strobe_oe(s[5]),
        .mem_chip_select_out(s[6]), .mem_chip_select_oe(s[7]),
        .mem_clock_enable_out(s[8]), .mem_clock_enable_oe(s[9]),
        .mem_clock_out_gated(s[10]), .mem_clock_out_alt(s[11]),
        .mem_address_line_out(s[24:12]), .mem_address_line_oe(s[37:25]),
        .mem_bank_address_out(s[39:38]), .mem_bank_address_oe(s[41:40]),
        .gpio_bank7_out(s[56:42]), .gpio_bank7_oe(s[71:57]),
        .gpio_bank3_bit13_out(s[72]), .gpio_bank3_bit13_oe(s[73]),
        .debug_return_clock_out(s[74]), .debug_return_clock_oe(s[75]), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_in_shared(pad_in_shared));
    periph_pad_model partner (.ref_clk(ref_clk), .rst(rst), .src_q(s), .lvl_q(pad_in));
    // 20 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Compares, counts and reports one value.
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One classic Wishbone cycle; the mirror takes a write at the acked edge.
    task automatic bus(input logic [4:0] a, input logic we, input logic [31:0] d,
                       input logic [3:0] sl);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sl;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        if (we && a[1:0] == 2'h0 && a[4:2] < 3'h5)
            for (int k = 0; k < 4; k++)
                if (sl[k]) shadow[a[4:2]][8 * k +: 8] = d[8 * k +: 8];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Expected {data, enable} of pad p from its mirrored selector and the sources.
    function automatic logic [1:0] pexp(input int p);
        logic [3:0] c;
        logic [1:0] a, b;
        int i, g;
        c = shadow[p < 7 ? 0 : p < 15 ? 1 : 2]
            [4 * (p < 6 ? 7 - p : p == 6 ? 0 : p < 15 ? 14 - p : 21 - p) +: 4];
        i = p < 13 ? 12 - p : 27 - p;
        g = p < 15 ? 14 - p : 29 - p;
        if (p == 4) return c == 4'h1 ? {s[10], 1'b1} : c == 4'h2 ? {s[11], 1'b1} : 2'h0;
        if (p < 6) return c == 4'h1 ? {s[2 * (p == 5 ? 4 : p)], s[2 * (p == 5 ? 4 : p) + 1]} : 2'h0;
        if (p == 6) return (c == 4'h0 || c == 4'h8) ? {s[74], s[75]} : c == 4'h1 ? {s[56], s[71]} : 2'h0;
        a = p == 13 ? {s[38], s[40]} : p == 14 ? {s[39], s[41]} : {s[12 + i], s[25 + i]};
        b = p == 15 ? {s[72], s[73]} : {s[42 + g], s[57 + g]};
        return c == 4'h1 ? a : c == 4'h8 ? b : 2'h0;
    endfunction
    // Pads are judged every cycle against what the previous edge should have picked.
    always @(negedge ref_clk) begin
        if (mon_on) begin
            check({10'h0, pad_out}, {10'h0, exp_o}, "pad data");
            check({10'h0, pad_oe}, {10'h0, exp_e}, "pad enable");
            check({10'h0, pad_in_shared}, {10'h0, in_q}, "shared input");
        end
        for (int p = 0; p < 22; p++) begin
            pe = pexp(p);
            exp_o[p] = pe[1];
            exp_e[p] = pe[0];
        end
        in_q = pad_in;
        mon_on = run_on;
    end
    // Reset values, and an unmapped write and read.
    task automatic t_reset();
        bus(5'h14, 1'b1, 32'hffff_ffff, 4'hf);
        for (int g = 0; g < 6; g++) begin
            bus(5'(4 * g), 1'b0, 32'h0, 4'hf);
            check(rd, 32'h0, "reset or unmapped read");
        end
    endtask
    // Full write, then a single byte lane, then readback.
    task automatic t_lanes();
        for (int g = 0; g < 5; g++) begin
            bus(5'(4 * g), 1'b1, 32'h5a3c_96e1 ^ 32'(g), 4'hf);
            bus(5'(4 * g), 1'b1, 32'hffff_ffff, 4'h4);
            bus(5'(4 * g), 1'b0, 32'h0, 4'hf);
            check(rd, (32'h5a3c_96e1 ^ 32'(g)) | 32'h00ff_0000, "readback");
        end
    endtask
    // Every code in every field, reserved ones included; pads watched meanwhile.
    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            for (int g = 0; g < 5; g++)
                bus(5'(4 * g), 1'b1, {8{4'(c)}}, 4'hf);
            repeat (6) @(posedge ref_clk);
            bus(5'h0c, 1'b0, 32'h0, 4'hf);
            check(rd, {8{4'(c)}}, "code kept");
        end
    endtask
    // Hang guard.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 44'h0};
        {run_on, mon_on} = 2'h0;
        foreach (shadow[k]) shadow[k] = 32'h0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        run_on = 1'b1;
        t_reset();
        t_lanes();
        t_codes();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
